// [pkg/interrupt_priority_config_params.svh]
`ifndef INTERRUPT_PRIORITY_CONFIG_PARAMS_SVH
`define INTERRUPT_PRIORITY_CONFIG_PARAMS_SVH

// ****************************************************************
// Register map (byte addresses, one aligned word each)
// ****************************************************************
`define ADDR_W 6
`define CPU_CTRL_OFS 6'h00
`define SRC_BASE_OFS 6'h04
`define SRC_STRIDE 6'h04
`define SRC_REGS_MAX 15

// ****************************************************************
// CPU priority control register fields
// ****************************************************************
`define CPU_EN_POS 7
`define XFER_LVL_LSB 4
`define AUTO_EN_POS 3
`define CPU_LVL_LSB 0

// ****************************************************************
// Source level register layout
// ****************************************************************
`define FIELDS_PER_REG 4
`define FIELD_PITCH 4
`define RSVD_MASK 16'h8888

// ****************************************************************
// Reset values
// ****************************************************************
`define CPU_EN_RESET 1'h0
`define AUTO_EN_RESET 1'h0
`define XFER_LVL_RESET 3'h0
`define CPU_LVL_RESET 3'h0
`define SRC_LVL_RESET 3'h7
`define LVL_LOWEST 3'h0

`endif

// [pkg/interrupt_priority_config_pkg.sv]
package interrupt_priority_config_pkg;

	typedef logic [2:0] level_t;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_DONE = 1'b1
	} bus_state_t;

	typedef enum logic [1:0] {
		MODE_BIT = 2'h0,
		MODE_LEVEL = 2'h2
	} ctrl_mode_t;

endpackage

// [core/interrupt_priority_config.sv]
`timescale 1ns/10ps
`include "interrupt_priority_config_params.svh"

// Contract
// - 3-bit CPU level in bits 2..0, 000 lowest, 111 highest, resets 000.
// - With CPU control enabled, CPU rank follows the CPU level field.
// - Auto set enabled: hardware owns the CPU field, writes ignored, still readable.
// - Every source but the non-maskable one gets a level 7..0.
// - Each 16-bit source register holds four 3-bit fields at 14:12,10:8,6:4,2:0.
// - Source fields are read/write and reset to all ones.
// - Source fields decode linearly, 000 lowest, 111 highest.
// - Bits 15, 11, 7, 3 of source registers read zero, ignore writes.
// - CPU control disabled: CPU always treated as lowest level.
// - Auto set copies the mask bit or the 3-bit mask level into the CPU field.
// - 3-bit transfer controller level, 000 lowest to 111 highest.

module interrupt_priority_config
	import interrupt_priority_config_pkg::*;
#(
	parameter int NUM_SRC_REGS = 9
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Avalon-MM slave
	input wire logic [`ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// CPU mask state
	input wire logic mask_bit,
	input wire logic [2:0] mask_level,
	input wire logic [1:0] control_mode,
	// Levels to arbitration
	output logic [2:0] cpu_level,
	output logic cpu_control_on,
	output logic [2:0] transfer_level,
	output logic [NUM_SRC_REGS*12-1:0] source_level
);

	localparam int NUM_FIELDS = NUM_SRC_REGS * `FIELDS_PER_REG;

	// ****************************************************************
	// Parameter check
	// ****************************************************************
	if (NUM_SRC_REGS < 1 || NUM_SRC_REGS > `SRC_REGS_MAX) begin : g_bad_count
		$error("NUM_SRC_REGS must lie between 1 and 15");
	end

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rst_meta;
	logic rst_n;

	// Assert at once, release two edges later so no flop sees a ragged release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ****************************************************************
	// Bus handshake
	// ****************************************************************
	bus_state_t bus_state;
	bus_state_t next_bus_state;
	wire bus_req = avs_read | avs_write;
	wire bus_idle = bus_state == BUS_IDLE;
	wire wr_take = avs_write & ~bus_idle;
	wire rd_load = avs_read & bus_idle;

	// Every access waits exactly one cycle; read data is registered meanwhile
	assign avs_waitrequest = bus_req & bus_idle;

	always_comb begin
		next_bus_state = bus_state;
		unique case (bus_state)
			BUS_IDLE: begin
				if (bus_req) begin
					next_bus_state = BUS_DONE;
				end
			end
			BUS_DONE: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_state <= BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// Read data was loaded while held off, so it stands once the wait drops
	a_read_wait_once: assert property (
		@(posedge clk) disable iff (!rst_n)
		rd_load |=> !avs_waitrequest
	) else $error("Read data not offered in the cycle after loading");

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire sel_cpu = avs_address == `CPU_CTRL_OFS;
	wire wr_cpu = wr_take & sel_cpu & avs_byteenable[0];
	logic [NUM_SRC_REGS-1:0] sel_src;

	// ****************************************************************
	// CPU priority control register
	// ****************************************************************
	logic cpu_en;
	logic auto_en;
	level_t xfer_field;
	level_t cpu_field;
	logic next_cpu_en;
	logic next_auto_en;
	level_t next_xfer_field;
	level_t next_cpu_field;
	level_t auto_value;

	// Mask level only counts in the 3-bit mask mode; prohibited codes act as bit mode
	assign auto_value = (control_mode == MODE_LEVEL) ? mask_level : {3{mask_bit}};

	assign next_cpu_en = wr_cpu ? avs_writedata[`CPU_EN_POS] : cpu_en;
	assign next_auto_en = wr_cpu ? avs_writedata[`AUTO_EN_POS] : auto_en;
	assign next_xfer_field = wr_cpu ? avs_writedata[`XFER_LVL_LSB +: 3] : xfer_field;

	// Hardware copy wins over a software write while auto set is on
	assign next_cpu_field = auto_en ? auto_value :
		(wr_cpu ? avs_writedata[`CPU_LVL_LSB +: 3] : cpu_field);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_en <= `CPU_EN_RESET;
			auto_en <= `AUTO_EN_RESET;
			xfer_field <= `XFER_LVL_RESET;
			cpu_field <= `CPU_LVL_RESET;
		end else begin
			cpu_en <= next_cpu_en;
			auto_en <= next_auto_en;
			xfer_field <= next_xfer_field;
			cpu_field <= next_cpu_field;
		end
	end

	// Without auto set only a write may move the field
	a_cpu_field_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!auto_en && !wr_cpu |=> $stable(cpu_field)
	) else $error("CPU field moved without a write");

	// Prohibited mode codes copy the single mask bit, as the bit mode does
	a_auto_bit_copy: assert property (
		@(posedge clk) disable iff (!rst_n)
		auto_en && control_mode != MODE_LEVEL |=> cpu_field == {3{$past(mask_bit)}}
	) else $error("CPU field did not take the mask bit");

	a_enable_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr_cpu |=> cpu_control_on == $past(avs_writedata[`CPU_EN_POS])
	) else $error("CPU control enable write lost");

	// Effective CPU level is registered so it moves on the same edge as its sources
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_level <= `LVL_LOWEST;
		end else if (next_cpu_en) begin
			cpu_level <= next_cpu_field;
		end else begin
			cpu_level <= `LVL_LOWEST;
		end
	end

	assign cpu_control_on = cpu_en;
	assign transfer_level = xfer_field;

	a_xfer_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!wr_cpu |=> $stable(transfer_level)
	) else $error("Transfer level moved without a write");

	// Enable, transfer level and effective level all leave reset together
	a_cpu_reset_low: assert property (
		@(posedge clk) disable iff (!rst_n)
		!$past(rst_n) |-> cpu_level == `LVL_LOWEST && transfer_level == `XFER_LVL_RESET
			&& cpu_control_on == `CPU_EN_RESET
	) else $error("CPU side not at reset values after reset");

	// ****************************************************************
	// Source level registers
	// ****************************************************************
	level_t src_field [NUM_FIELDS];
	logic [15:0] src_word [NUM_SRC_REGS];
	logic [15:0] rd_chain [NUM_SRC_REGS+1];

	assign rd_chain[0] = sel_cpu ?
		{8'h00, cpu_en, xfer_field, auto_en, cpu_field} : 16'h0000;

	// The non-maskable source is not part of this array: it has no field
	for (genvar r = 0; r < NUM_SRC_REGS; r++) begin : g_reg
		localparam logic [`ADDR_W-1:0] OFS = `ADDR_W'(`SRC_BASE_OFS + r * `SRC_STRIDE);

		assign sel_src[r] = avs_address == OFS;

		// Spare bit above each field stays zero and has no storage
		assign src_word[r] = {1'b0, src_field[r*4+3], 1'b0, src_field[r*4+2],
			1'b0, src_field[r*4+1], 1'b0, src_field[r*4]};
		assign rd_chain[r+1] = rd_chain[r] | (sel_src[r] ? src_word[r] : 16'h0000);

		for (genvar f = 0; f < `FIELDS_PER_REG; f++) begin : g_field
			localparam int LSB = f * `FIELD_PITCH;
			wire fld_wr = wr_take & sel_src[r] & avs_byteenable[f/2];

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					src_field[r*4+f] <= `SRC_LVL_RESET;
				end else if (fld_wr) begin
					src_field[r*4+f] <= avs_writedata[LSB +: 3];
				end
			end

			// Plain binary code is the level itself
			assign source_level[(r*4+f)*3 +: 3] = src_field[r*4+f];
		end
	end

	// Lane 0 carries fields 0 and 1; leaving it off must keep both
	a_lane_mask: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr_take && sel_src[0] && !avs_byteenable[0]
		|=> source_level[5:0] == $past(source_level[5:0])
	) else $error("Source field written through a disabled lane");

	// Arbitration must never see a level change that software did not ask for
	a_src_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!wr_take |=> $stable(source_level)
	) else $error("Source level moved without a write");

	// ****************************************************************
	// Read data
	// ****************************************************************
	// Unmapped addresses fall out of the chain as zero
	wire [15:0] rd_word = rd_chain[NUM_SRC_REGS];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_load) begin
			avs_readdata <= {16'h0000, rd_word};
		end
	end

	// Only 16-bit registers sit behind the bus
	a_read_upper_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		avs_readdata[31:16] == 16'h0000
	) else $error("Upper read data half not zero");

	// An address that selects nothing must read as zero, not as a stale word
	a_unmapped_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		rd_load && !sel_cpu && sel_src == '0 |=> avs_readdata == 32'h0000_0000
	) else $error("Unmapped address did not read zero");

	a_read_src_word: assert property (
		@(posedge clk) disable iff (!rst_n)
		rd_load && sel_src[0] |=> avs_readdata[15:0] == {1'b0, $past(source_level[11:9]),
			1'b0, $past(source_level[8:6]), 1'b0, $past(source_level[5:3]),
			1'b0, $past(source_level[2:0])}
	) else $error("Source register read does not match its levels");

	a_cpu_read_back: assert property (
		@(posedge clk) disable iff (!rst_n)
		rd_load && sel_cpu
		|=> avs_readdata[7:0] == $past({cpu_en, xfer_field, auto_en, cpu_field})
	) else $error("CPU control register read does not match its fields");

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_cpu_lowest_off: assert property (
		@(posedge clk) disable iff (!rst_n)
		!cpu_en |-> cpu_level == `LVL_LOWEST
	) else $error("CPU level not lowest while control is off");

	a_cpu_follow_field: assert property (
		@(posedge clk) disable iff (!rst_n)
		cpu_en |-> cpu_level == cpu_field
	) else $error("CPU level does not follow its field");

	a_auto_copy_mask: assert property (
		@(posedge clk) disable iff (!rst_n)
		auto_en && control_mode == MODE_LEVEL |=> cpu_field == $past(mask_level)
	) else $error("CPU field did not take the mask level");

	a_auto_blocks_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		auto_en && wr_cpu && control_mode != MODE_LEVEL
		|=> cpu_field == {3{$past(mask_bit)}}
	) else $error("Software write reached CPU field under auto set");

	a_cpu_field_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr_cpu && !auto_en |=> cpu_field == $past(avs_writedata[2:0])
	) else $error("CPU field write lost");

	a_xfer_field_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr_cpu |=> transfer_level == $past(avs_writedata[6:4])
	) else $error("Transfer level write lost");

	a_src_reset_high: assert property (
		@(posedge clk) disable iff (!rst_n)
		!$past(rst_n) |-> source_level[2:0] == 3'h7
			&& source_level[NUM_SRC_REGS*12-1 -: 3] == 3'h7
	) else $error("Source level not highest after reset");

	a_src_write_out: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr_take && sel_src[0] && avs_byteenable[1]
		|=> source_level[11:9] == $past(avs_writedata[14:12])
	) else $error("Source level output did not take the write");

	a_src_spare_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		rd_load && sel_src[0] |=> (avs_readdata[15:0] & `RSVD_MASK) == 16'h0000
	) else $error("Spare source bit read as one");

	a_wait_one: assert property (
		@(posedge clk) disable iff (!rst_n)
		bus_req && avs_waitrequest |=> !avs_waitrequest
	) else $error("Access held off for more than one cycle");

endmodule // interrupt_priority_config

// [tb/cpu_mask_model.sv]
`timescale 1ns/10ps

module cpu_mask_model (
	// Clock
	input wire logic clk,
	// Bench control
	input wire logic hold,
	input wire logic [1:0] mode,
	// Mask state toward the block
	output logic mask_bit,
	output logic [2:0] mask_level,
	output logic [1:0] control_mode
);
	integer seed = 32'hb4c0a57f;
	logic held_bit = 1'b0;
	logic [2:0] held_level = 3'h0;

	assign control_mode = mode;
	assign mask_bit = held_bit;
	assign mask_level = held_level;

	// Mask moves every cycle while hold is low so that the copy is exercised at full rate
	always @(posedge clk) begin
		if (!hold) begin
			held_bit <= 1'($random(seed));
			held_level <= 3'($random(seed));
		end
	end
endmodule // cpu_mask_model

// [tb/test_interrupt_priority_config.sv]
`timescale 1ns/10ps
`include "interrupt_priority_config_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end

module test_interrupt_priority_config
	import interrupt_priority_config_pkg::*;
;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [`ADDR_W-1:0] adr = 6'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'h0;
	logic [31:0] rdata;
	logic wait_req;
	logic hold = 1'b0;
	logic [1:0] mode = 2'h2;
	logic mask_bit;
	logic [2:0] mask_level;
	logic [1:0] control_mode;
	logic [2:0] cpu_level;
	logic ctl_on;
	logic [2:0] xfer_lvl;
	logic [107:0] src_lvl;
	int failures = 0;
	int checks = 0;
	integer seed = 32'hb4c0a57f;
	logic [15:0] model [0:8];
	logic [31:0] got;
	logic [31:0] wd;
	logic [3:0] lanes;
	logic [2:0] m;
	logic b;
	int i;
	int k;

	interrupt_priority_config #(.NUM_SRC_REGS(9)) interrupt_priority_config_inst (
		.clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd_en),
		.avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(be),
		.avs_readdata(rdata), .avs_waitrequest(wait_req), .mask_bit(mask_bit),
		.mask_level(mask_level), .control_mode(control_mode), .cpu_level(cpu_level),
		.cpu_control_on(ctl_on), .transfer_level(xfer_lvl), .source_level(src_lvl));

	cpu_mask_model cpu_mask_model_inst (.clk(clk), .hold(hold), .mode(mode),
		.mask_bit(mask_bit), .mask_level(mask_level), .control_mode(control_mode));

	initial begin
		forever #2.5 clk = ~clk;
	end

	// ****************************************************************
	// Expectations and bus access
	// ****************************************************************
	function automatic logic [15:0] merge(logic [15:0] old, logic [15:0] v, logic [3:0] l);
		merge = old;
		if (l[0]) merge[7:0] = v[7:0];
		if (l[1]) merge[15:8] = v[15:8];
		merge = merge & 16'h7777;
	endfunction

	function automatic logic [11:0] pack(logic [15:0] r);
		pack = {r[14:12], r[10:8], r[6:4], r[2:0]};
	endfunction

	function automatic logic [5:0] ad(int n);
		ad = 6'(4 + 4 * n);
	endfunction

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] v,
		input logic [3:0] l, output logic [31:0] rd);
		int n;
		rd = 32'h0;
		@(posedge clk);
		rd_en <= !we;
		wr_en <= we;
		adr <= a;
		wdata <= v;
		be <= l;
		// Read right after the edge, the design still shows what it showed before it
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (!wait_req) break;
		end
		if (n == 20) begin
			failures++;
			print_verdict();
		end else begin
			rd = rdata;
			rd_en <= 1'b0;
			wr_en <= 1'b0;
			#1;
		end
	endtask

	task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf, got);
		`CHK(got, exp)
	endtask

	task automatic src_chk();
		for (int n = 0; n < 9; n++) begin
			`CHK(src_lvl[n*12+:12], pack(model[n]))
		end
	endtask

	// Releases reset after four edges and checks every reset value
	task automatic reset_chk();
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		`CHK(cpu_level, 3'h0)
		`CHK(xfer_lvl, 3'h0)
		`CHK(ctl_on, 1'b0)
		`CHK(src_lvl, {108{1'b1}})
		rchk(6'h00, 32'h0);
		for (int n = 0; n < 9; n++) begin
			model[n] = 16'h7777;
			rchk(ad(n), 32'h7777);
		end
	endtask

	initial begin
		reset_chk();
		// Two corner words first, then random words and lane masks
		for (k = 0; k < 40; k++) begin
			i = $unsigned($random(seed)) % 9;
			wd = (k < 2) ? {32{k[0]}} : $random(seed);
			lanes = (k < 2) ? 4'hf : 4'($random(seed));
			bus(1'b1, ad(i), wd, lanes, got);
			model[i] = merge(model[i], wd[15:0], lanes);
			src_chk();
			rchk(ad(i), {16'h0, model[i]});
		end
		bus(1'b1, 6'h28, 32'hffffffff, 4'hf, got);
		src_chk();
		rchk(6'h28, 32'h0);
		rchk(6'h3c, 32'h0);
		for (i = 0; i < 8; i++) begin
			bus(1'b1, 6'h00, 32'(8'h80 | (i << 4) | i), 4'h1, got);
			`CHK(cpu_level, 3'(i))
			`CHK(xfer_lvl, 3'(i))
			rchk(6'h00, 32'(8'h80 | (i << 4) | i));
		end
		bus(1'b1, 6'h00, 32'h05, 4'h1, got);
		`CHK(cpu_level, 3'h0)
		`CHK(ctl_on, 1'b0)
		rchk(6'h00, 32'h05);
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			mode <= 2'(i);
			bus(1'b1, 6'h00, 32'h88, 4'h1, got);
			for (k = 0; k < 8; k++) begin
				b = mask_bit;
				m = mask_level;
				@(posedge clk);
				#1;
				`CHK(cpu_level, (i == 2) ? m : {3{b}})
			end
		end
		@(posedge clk);
		mode <= 2'h2;
		hold <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		m = mask_level;
		bus(1'b1, 6'h00, {24'h0, 8'h88 | {5'h0, ~m}}, 4'h1, got);
		`CHK(cpu_level, m)
		rchk(6'h00, 32'h88 | 32'(m));
		// A second reset in mid-run must bring every field back to its reset value
		@(posedge clk);
		resetn <= 1'b0;
		reset_chk();
		print_verdict();
	end
endmodule // test_interrupt_priority_config
